// *** vdi_pkg.sv ***
package vdi_pkg;
   // ****************************************
   // bus addresses (8-bit, with direction bit)
   // ****************************************
   localparam logic [7:0] WR_ADDR_LO = 8'hb8;
   localparam logic [7:0] WR_ADDR_HI = 8'hba;
   localparam logic [7:0] RD_ADDR_LO = 8'hb9;
   localparam logic [7:0] RD_ADDR_HI = 8'hbb;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS         = 50;
   localparam int MAX_RATE_KBPS  = 400;
   // shortest scl high/low half-period at the top rate, in cycles
   localparam int HALF_BIT_CYC   = (1000000 / MAX_RATE_KBPS) / 2 / CLK_NS;
   localparam int SLOW_WAIT_US   = 64;
   localparam int SLOW_WAIT_CYC  = (SLOW_WAIT_US * 1000) / CLK_NS;
   localparam logic [7:0] SLOW_LAST_SUB = 8'h8f;
   localparam int BITS_PER_BYTE  = 8;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic scl;
      logic sda;
   } vdi_line_s;
   typedef struct packed {
      logic       we;
      logic       re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vdi_reg_req_s;
endpackage : vdi_pkg

// *** vdi_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdi_sync (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // raw pin levels
   input  wire vdi_pkg::vdi_line_s pin_in,
   // filtered levels
   output var  vdi_pkg::vdi_line_s line_q
);
   import vdi_pkg::*;
   vdi_line_s s1_q;
   vdi_line_s s2_q;
   vdi_line_s s3_q;
   // ****************************************
   // three-stage sampler, change when 2nd and 3rd agree
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_q   <= '1;
         s2_q   <= '1;
         s3_q   <= '1;
         line_q <= '1;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q.scl == s3_q.scl) begin
            line_q.scl <= s3_q.scl;
         end
         if (s2_q.sda == s3_q.sda) begin
            line_q.sda <= s3_q.sda;
         end
      end
   end
endmodule : vdi_sync
`default_nettype wire

// *** vdi_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - target only, never starts or clocks
// - capture address strap once after reset
// - write address b8h low, bah high
// - read address b9h low, bbh high
// - works at any rate to 400 kbit/s
// - data changes only while clock low
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - eight-bit bytes, any byte count
// - receiver drives ninth acknowledge bit
// - ack address, subaddress and each data
// - subaddress byte stores read pointer
// - read address acked, data msb first
// - on not-acknowledge release sda, stop reading
// - hold scl low during acknowledge of received bytes while internal side busy
module vdi_slave (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   // two-wire bus pins
   input  wire logic               scl_in,
   output logic                    scl_out,
   output logic                    scl_oe,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   // address strap
   input  wire logic               bus_address_select_strap,
   // internal register access
   output vdi_pkg::vdi_reg_req_s   reg_req_q,
   input  wire logic [7:0]         reg_rdata,
   input  wire logic               reg_busy,
   // status
   output logic                    sel_q
);
   import vdi_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
   } vdi_state_e;

   vdi_line_s  line;
   vdi_line_s  prev_q;
   vdi_state_e state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic       have_sub_q;
   logic       strap_done_q;
   logic       sda_drv_q;
   logic       scl_hold_q;
   logic       ack_pending_q;

   // ****************************************
   // pin sampling
   // ****************************************
   vdi_sync u_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pin_in  ({scl_in, sda_in}),
      .line_q  (line)
   );

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= '1;
      end else begin
         prev_q <= line;
      end
   end

   wire logic scl_rise  = line.scl & ~prev_q.scl;
   wire logic scl_fall  = ~line.scl & prev_q.scl;
   wire logic start_det = line.scl & prev_q.scl & prev_q.sda & ~line.sda;
   wire logic stop_det  = line.scl & prev_q.scl & ~prev_q.sda & line.sda;

   // ****************************************
   // address strap capture
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         strap_done_q <= 1'b0;
         sel_q        <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         sel_q        <= bus_address_select_strap;
      end
   end

   function automatic logic addr_match(input logic [7:0] a, input logic sel);
      if (a[0]) begin
         addr_match = (a == (sel ? RD_ADDR_HI : RD_ADDR_LO));
      end else begin
         addr_match = (a == (sel ? WR_ADDR_HI : WR_ADDR_LO));
      end
   endfunction : addr_match

   // ****************************************
   // protocol engine
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= ST_IDLE;
         bit_q      <= 4'h0;
         shift_q    <= 8'h00;
         ptr_q      <= 8'h00;
         have_sub_q <= 1'b0;
         sda_drv_q  <= 1'b0;
         reg_req_q  <= '0;
         ack_pending_q <= 1'b0;
      end else begin
         reg_req_q.we <= 1'b0;
         reg_req_q.re <= 1'b0;
         reg_req_q.addr <= ptr_q;
         if (start_det) begin
            state_q    <= ST_ADDR;
            bit_q      <= 4'h0;
            have_sub_q <= 1'b0;
            sda_drv_q  <= 1'b0;
         end else if (stop_det) begin
            state_q   <= ST_IDLE;
            sda_drv_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_drv_q <= 1'b0;
               end
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], line.sda};
                     bit_q   <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'(BITS_PER_BYTE)) begin
                     bit_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (addr_match(shift_q, sel_q)) begin
                           sda_drv_q <= 1'b1;
                           state_q   <= ST_ADDR_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        sda_drv_q <= 1'b1;
                        state_q   <= ST_RX_ACK;
                        if (!have_sub_q) begin
                           ptr_q      <= shift_q;
                           have_sub_q <= 1'b1;
                        end else begin
                           reg_req_q.we    <= 1'b1;
                           reg_req_q.addr  <= ptr_q;
                           reg_req_q.wdata <= shift_q;
                           ptr_q           <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
               ST_ADDR_ACK, ST_RX_ACK: begin
                  if (scl_fall && !scl_hold_q) begin
                     if (state_q == ST_ADDR_ACK && shift_q[0]) begin
                        state_q   <= ST_TX;
                        shift_q   <= reg_rdata;
                        sda_drv_q <= ~reg_rdata[7];
                        bit_q     <= 4'h1;
                        reg_req_q.re   <= 1'b1;
                        reg_req_q.addr <= ptr_q;
                        ptr_q          <= ptr_q + 8'h01;
                     end else begin
                        state_q   <= ST_RX;
                        sda_drv_q <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'(BITS_PER_BYTE)) begin
                        sda_drv_q <= 1'b0;
                        state_q   <= ST_TX_ACK;
                     end else begin
                        sda_drv_q <= ~shift_q[3'(7 - bit_q)];
                        bit_q     <= bit_q + 4'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) begin
                     ack_pending_q <= ~line.sda;
                  end else if (scl_fall) begin
                     if (ack_pending_q) begin
                        shift_q   <= reg_rdata;
                        sda_drv_q <= ~reg_rdata[7];
                        bit_q     <= 4'h1;
                        state_q   <= ST_TX;
                        reg_req_q.re   <= 1'b1;
                        reg_req_q.addr <= ptr_q;
                        ptr_q          <= ptr_q + 8'h01;
                     end else begin
                        sda_drv_q <= 1'b0;
                        state_q   <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // clock stretch during acknowledge while busy
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         scl_hold_q <= 1'b0;
      end else begin
         if (scl_fall && bit_q == 4'(BITS_PER_BYTE) &&
             (state_q == ST_RX || (state_q == ST_ADDR && addr_match(shift_q, sel_q)))) begin
            scl_hold_q <= reg_busy;
         end else if (!reg_busy || (state_q != ST_ADDR_ACK && state_q != ST_RX_ACK)) begin
            scl_hold_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // open-drain outputs
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         sda_oe  <= sda_drv_q;
         scl_out <= 1'b0;
         scl_oe  <= scl_hold_q;
      end
   end
endmodule : vdi_slave
`default_nettype wire

// *** vdi_slave_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdi_slave_monitor (
   // design ports
   input wire logic                  clk_sys,
   input wire logic                  rst_b,
   input wire logic                  scl_in,
   input wire logic                  scl_out,
   input wire logic                  scl_oe,
   input wire logic                  sda_out,
   input wire logic                  sda_oe,
   input wire logic                  bus_address_select_strap,
   input wire vdi_pkg::vdi_reg_req_s reg_req_q,
   input wire logic                  reg_busy,
   input wire logic                  sel_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_byte_in;
      $rose(reg_req_q.we);
   endsequence
   sequence s_ack_out;
      ##[0:10] sda_oe;
   endsequence
   a_never_drive_hi:
      assert property (!scl_out && !sda_out) else $error("pin driven high");
   a_sda_move_low:
      assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
   a_oe_stands:
      assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("sda bit too short");
   a_sel_capture:
      assert property ($rose(rst_b) |=> sel_q == $past(bus_address_select_strap)) else $error("strap not taken");
   a_sel_held:
      assert property ($past(rst_b) && $past(rst_b, 2) |-> $stable(sel_q)) else $error("strap changed");
   a_data_acked:
      assert property (s_byte_in |-> s_ack_out) else $error("data byte not acked");
   a_we_pulse:
      assert property (reg_req_q.we |=> !reg_req_q.we) else $error("write pulse too long");
   a_re_pulse:
      assert property (reg_req_q.re |=> !reg_req_q.re) else $error("read pulse too long");
   a_stretch_cause:
      assert property ($rose(scl_oe) |-> $past(reg_busy) || $past(reg_busy, 2)) else $error("stretch without busy");
   a_stretch_end:
      assert property (!reg_busy[*4] |=> !scl_oe) else $error("stretch held while idle");
endmodule : vdi_slave_monitor
bind vdi_slave vdi_slave_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .bus_address_select_strap(bus_address_select_strap),
   .reg_req_q(reg_req_q), .reg_busy(reg_busy), .sel_q(sel_q));
`default_nettype wire

// *** vdi_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdi_master_model #(
   parameter int HALF = 25
) (
   // clock and bus levels
   input wire logic clk_sys,
   input wire logic scl,
   input wire logic sda,
   // pulls, high = line held low, and stretch timeout flag
   output logic     scl_oe_m,
   output logic     sda_oe_m,
   output logic     timed_out
);
   initial begin
      scl_oe_m = 1'b0;
      sda_oe_m = 1'b0;
      timed_out = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc
   // release scl, follow a stretch
   task automatic scl_high();
      int k;
      k = 0;
      scl_oe_m = 1'b0;
      while (!scl && k < 4000) begin
         wait_cyc(1);
         k++;
      end
      if (!scl) timed_out = 1'b1;
      wait_cyc(HALF);
   endtask : scl_high
   task automatic start();
      sda_oe_m = 1'b0;
      scl_high();
      sda_oe_m = 1'b1;
      wait_cyc(HALF);
      scl_oe_m = 1'b1;
   endtask : start
   task automatic stop();
      wait_cyc(HALF / 2);
      sda_oe_m = 1'b1;
      wait_cyc(HALF - HALF / 2);
      scl_high();
      sda_oe_m = 1'b0;
      wait_cyc(HALF);
   endtask : stop
   // eight bits msb first, then ninth bit
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         wait_cyc(HALF / 2);
         sda_oe_m = (i < 0) ? !ack_in : !d[i];
         wait_cyc(HALF - HALF / 2);
         scl_high();
         if (i >= 0) q[i] = sda;
         ack = sda;
         scl_oe_m = 1'b1;
      end
   endtask : xfer
endmodule : vdi_master_model
`default_nettype wire

// *** vdi_slave_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdi_slave_tb;
   import vdi_pkg::*;
   logic         clk_sys, rst_b, strap, reg_busy, scl_oe, sda_oe, sel_q, ak;
   logic         stretched;
   logic [7:0]   mem [256];
   logic [7:0]   exp_mem [256];
   logic [7:0]   q, wa, ra, sub, d;
   vdi_reg_req_s reg_req_q;
   wire logic    scl_oe_m, sda_oe_m, timed_out;
   wire logic    scl = !(scl_oe | scl_oe_m);
   wire logic    sda = !(sda_oe | sda_oe_m);
   wire logic [7:0] reg_rdata = mem[reg_req_q.addr];
   int           errors, tests_run, seed;
   vdi_slave i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .bus_address_select_strap(strap), .reg_req_q(reg_req_q),
      .reg_rdata(reg_rdata), .reg_busy(reg_busy), .sel_q(sel_q));
   vdi_master_model #(.HALF(HALF_BIT_CYC)) i_master (.clk_sys(clk_sys), .scl(scl), .sda(sda),
      .scl_oe_m(scl_oe_m), .sda_oe_m(sda_oe_m), .timed_out(timed_out));
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      #1;
      reg_busy <= (($random(seed) & 31) == 0) ? ~reg_busy : reg_busy;
   end
   always @(posedge clk_sys) begin
      if (scl_oe && !scl_oe_m) stretched <= 1'b1;
   end
   always @(posedge clk_sys) begin
      if (reg_req_q.we) mem[reg_req_q.addr] <= reg_req_q.wdata;
   end
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, want, got);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic send(input logic [7:0] b, input logic [7:0] want, input string nm);
      i_master.xfer(b, 1'b1, q, ak);
      check(nm, {7'h0, ak}, want);
   endtask : send
   initial begin
      repeat (100000) @(posedge clk_sys);
      errors++;
      end_sim();
   end
   initial begin
      clk_sys = 0;
      rst_b = 0;
      strap = 0;
      reg_busy = 0;
      stretched = 0;
      seed = 32'h329c;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
      exp_mem = mem;
      for (int s = 0; s < 2; s++) begin
         strap = s[0];
         rst_b = 0;
         repeat (2) @(posedge clk_sys);
         #1 rst_b = 1;
         repeat (4) @(posedge clk_sys);
         check("sel", {7'h0, sel_q}, {7'h0, strap});
         wa = s ? WR_ADDR_HI : WR_ADDR_LO;
         ra = s ? RD_ADDR_HI : RD_ADDR_LO;
         sub = s ? 8'hfe : 8'($random(seed));
         i_master.start();
         send(wa, 8'h0, "wr_addr");
         send(sub, 8'h0, "sub");
         for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            exp_mem[8'(sub + i)] = d;
            send(d, 8'h0, "data");
         end
         if (sub <= SLOW_LAST_SUB || 8'(sub + 2) <= SLOW_LAST_SUB) i_master.wait_cyc(SLOW_WAIT_CYC);
         i_master.stop();
         for (int i = 0; i < 3; i++) check("written", mem[8'(sub + i)], exp_mem[8'(sub + i)]);
         i_master.start();
         send(wa, 8'h0, "ph1_addr");
         send(sub, 8'h0, "ph1_sub");
         i_master.stop();
         i_master.start();
         send(ra, 8'h0, "rd_addr");
         for (int i = 0; i < 3; i++) begin
            i_master.xfer(8'hff, i == 2, q, ak);
            check("rd_data", q, exp_mem[8'(sub + i)]);
         end
         i_master.stop();
         check("sda_free", {7'h0, sda_oe}, 8'h0);
         for (int j = 0; j < 2; j++) begin
            i_master.start();
            send((j ? ra : wa) ^ 8'h02, 8'h1, "foreign");
            send(8'h00, 8'h1, "idle");
            i_master.stop();
         end
      end
      check("stretch", {7'h0, timed_out}, 8'h0);
      check("stretched", {7'h0, stretched}, 8'h1);
      end_sim();
   end
endmodule : vdi_slave_tb
`default_nettype wire
